// File: logic/isc_defs.svh
`ifndef ISC_DEFS_SVH
`define ISC_DEFS_SVH

// register byte addresses
`define ISC_ADDR_IN_SERVICE 32'h01E00020
`define ISC_ADDR_MASTER_PRIO 32'h01E0001C
`define ISC_ADDR_IRQ_CLEAR 32'h01E00024
`define ISC_ADDR_FIQ_CLEAR 32'h01E0003C
`define ISC_ADDR_INT_STATUS 32'h01E000F0
`define ISC_ADDR_INT_MASK 32'h01E000F4

// field layout
`define ISC_NSRC 26
`define ISC_SRC_MSB 25
`define ISC_BRANCH_LSB 8
`define ISC_BRANCH_W 6
`define ISC_PRIO_W 8

// reset values
`define ISC_SERVICE_RST 26'h0000000
`define ISC_PRIO_RST 8'h1B

// local status bits
`define ISC_EV_IRQ_END 0
`define ISC_EV_FIQ_END 1
`define ISC_EV_STRAY 2
`define ISC_NEV 3

`endif

// File: logic/isc_pkg.sv
`include "isc_defs.svh"

package isc_pkg;

    typedef logic [`ISC_SRC_MSB:0] isc_src_t;

    typedef enum logic [1:0]
    {
        isc_idle,
        isc_serving,
        isc_closing
    } isc_state_t;

endpackage : isc_pkg

// File: logic/isc_onehot.sv
`include "isc_defs.svh"

module isc_onehot
    import isc_pkg::*;
#(
    parameter int NSRC = `ISC_NSRC
)
(
    input wire logic [NSRC-1:0] req,
    output logic [NSRC-1:0] grant
);

    // highest bit wins so the register never shows two sources
    always_comb
    begin
        grant = '0;
        for (int i = 0; i < NSRC; i++)
        begin
            if (req[i])
            begin
                grant = '0;
                grant[i] = 1'b1;
            end
        end
    end

endmodule : isc_onehot

// File: logic/isc_events.sv
`include "isc_defs.svh"

module isc_events
    import isc_pkg::*;
#(
    parameter int NEV = `ISC_NEV
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [NEV-1:0] event_in,
    input wire logic mask_wr,
    input wire logic status_wr,
    input wire logic [NEV-1:0] wdata,
    output logic [NEV-1:0] status,
    output logic [NEV-1:0] mask,
    output logic irq
);

    logic [NEV-1:0] status_r;
    logic [NEV-1:0] status_nxt;
    logic [NEV-1:0] mask_r;
    logic [NEV-1:0] mask_nxt;

    // a new event wins over a write-one clear in the same cycle
    always_comb
    begin
        status_nxt = status_r;
        mask_nxt = mask_r;
        if (status_wr)
        begin
            status_nxt = status_r & ~wdata;
        end
        status_nxt = status_nxt | event_in;
        if (mask_wr)
        begin
            mask_nxt = wdata;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            status_r <= '0;
            mask_r <= '0;
        end
        else
        begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
        end
    end

    assign status = status_r;
    assign mask = mask_r;
    assign irq = |(status_r & mask_r);

endmodule : isc_events

// File: logic/isc_service.sv
// How it works
// - service register holds only one set bit
// - bit 25 external line zero, bit 0 converter
// - writing one clears pending, zero keeps it
// - clear write ends service, drops in-service bit
// - pending register has no direct write path
// - broken discipline may show zero everywhere
// - separate irq and fiq clear registers
// - service register reads zero after reset
// - priority register exposes branch code bits 13:8
//
// The implementer's own choice: strobed register access.
`include "isc_defs.svh"

module isc_service
    import isc_pkg::*;
#(
    parameter int NSRC = `ISC_NSRC
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [NSRC-1:0] pend_set,
    input wire logic [NSRC-1:0] win_src,
    input wire logic [`ISC_BRANCH_W-1:0] win_branch,
    input wire logic [`ISC_PRIO_W-1:0] cur_prio,
    input wire logic irq_ack,
    output logic [NSRC-1:0] source_pending_bits,
    output logic [NSRC-1:0] irq_in_service,
    output logic service_end,
    output logic irq
);

    // ************************************************************
    // bus decode
    // ************************************************************
    logic irq_clr_wr;
    logic fiq_clr_wr;
    logic st_wr;
    logic mk_wr;
    logic [NSRC-1:0] clr_bits;

    assign irq_clr_wr = wr && (addr == `ISC_ADDR_IRQ_CLEAR);
    assign fiq_clr_wr = wr && (addr == `ISC_ADDR_FIQ_CLEAR);
    assign st_wr = wr && (addr == `ISC_ADDR_INT_STATUS);
    assign mk_wr = wr && (addr == `ISC_ADDR_INT_MASK);
    // both clear registers share the 26-bit source layout
    assign clr_bits = (irq_clr_wr || fiq_clr_wr) ?
        wdata[NSRC-1:0] : '0;

    // ************************************************************
    // pending bits
    // ************************************************************
    logic [NSRC-1:0] pend_r;
    logic [NSRC-1:0] pend_nxt;

    // no address writes the pending bits directly
    // a fresh request beats a clear in the same cycle
    always_comb
    begin
        pend_nxt = (pend_r & ~clr_bits) | pend_set;
    end

    // ************************************************************
    // in-service tracking
    // ************************************************************
    isc_state_t state_r;
    isc_state_t state_nxt;
    logic [NSRC-1:0] svc_r;
    logic [NSRC-1:0] svc_nxt;
    logic [`ISC_BRANCH_W-1:0] branch_r;
    logic [`ISC_BRANCH_W-1:0] branch_nxt;
    logic [NSRC-1:0] win_one;
    logic end_r;
    logic end_nxt;
    logic stray;

    isc_onehot #(
        .NSRC(NSRC)
    ) u_onehot (
        .req(win_src & pend_r),
        .grant(win_one)
    );

    // a clear that hits no serviced source is flagged; this is
    // how misuse of the clear path becomes visible
    assign stray = (|clr_bits) && ((clr_bits & svc_r) == '0);

    always_comb
    begin
        state_nxt = state_r;
        svc_nxt = svc_r;
        branch_nxt = branch_r;
        end_nxt = 1'b0;
        case (state_r)
            isc_idle:
            begin
                if (irq_ack && (|win_one))
                begin
                    svc_nxt = win_one;
                    branch_nxt = win_branch;
                    state_nxt = isc_serving;
                end
            end
            isc_serving:
            begin
                if (|(clr_bits & svc_r))
                begin
                    svc_nxt = '0;
                    end_nxt = 1'b1;
                    state_nxt = isc_closing;
                end
            end
            isc_closing:
            begin
                // one idle cycle so the old winner is not re-accepted
                state_nxt = isc_idle;
            end
            default:
            begin
                state_nxt = isc_idle;
                svc_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            pend_r <= '0;
            svc_r <= `ISC_SERVICE_RST;
            branch_r <= '0;
            state_r <= isc_idle;
            end_r <= 1'b0;
        end
        else
        begin
            pend_r <= pend_nxt;
            svc_r <= svc_nxt;
            branch_r <= branch_nxt;
            state_r <= state_nxt;
            end_r <= end_nxt;
        end
    end

    assign source_pending_bits = pend_r;
    assign irq_in_service = svc_r;
    assign service_end = end_r;

    // ************************************************************
    // event status and mask
    // ************************************************************
    logic [`ISC_NEV-1:0] ev_in;
    logic [`ISC_NEV-1:0] ev_status;
    logic [`ISC_NEV-1:0] ev_mask;

    always_comb
    begin
        ev_in = '0;
        ev_in[`ISC_EV_IRQ_END] = irq_clr_wr && (|(clr_bits & svc_r));
        ev_in[`ISC_EV_FIQ_END] = fiq_clr_wr && (|(clr_bits & svc_r));
        ev_in[`ISC_EV_STRAY] = stray;
    end

    isc_events #(
        .NEV(`ISC_NEV)
    ) u_events (
        .clock(clock),
        .rstn(rstn),
        .event_in(ev_in),
        .mask_wr(mk_wr),
        .status_wr(st_wr),
        .wdata(wdata[`ISC_NEV-1:0]),
        .status(ev_status),
        .mask(ev_mask),
        .irq(irq)
    );

    // ************************************************************
    // read data, one cycle after the strobe
    // ************************************************************
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    always_comb
    begin
        rdata_nxt = '0;
        if (rd)
        begin
            case (addr)
                `ISC_ADDR_IN_SERVICE:
                    rdata_nxt[NSRC-1:0] = svc_r;
                `ISC_ADDR_MASTER_PRIO:
                begin
                    rdata_nxt[`ISC_BRANCH_LSB +: `ISC_BRANCH_W] =
                        branch_r;
                    rdata_nxt[`ISC_PRIO_W-1:0] = cur_prio;
                end
                `ISC_ADDR_INT_STATUS:
                    rdata_nxt[`ISC_NEV-1:0] = ev_status;
                `ISC_ADDR_INT_MASK:
                    rdata_nxt[`ISC_NEV-1:0] = ev_mask;
                // clear registers are write-only and read zero
                default:
                    rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_r <= '0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

endmodule : isc_service

// File: tb/isc_service_monitor.sv
`include "isc_defs.svh"
module isc_mon
    import isc_pkg::*;
#(
    parameter int NSRC = 26
)
(
    input logic clock,
    input logic rstn,
    input logic [31:0] addr,
    input logic [31:0] wdata,
    input logic wr,
    input logic rd,
    input logic [31:0] rdata,
    input logic [NSRC-1:0] pend_set,
    input logic [NSRC-1:0] win_src,
    input logic irq_ack,
    input logic [NSRC-1:0] source_pending_bits,
    input logic [NSRC-1:0] irq_in_service,
    input logic service_end
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // clear decode
    // ********
    wire [NSRC-1:0] pb = source_pending_bits;
    wire [NSRC-1:0] svc = irq_in_service;
    wire [NSRC-1:0] wm = wdata[NSRC-1:0];
    wire fclr = addr == `ISC_ADDR_FIQ_CLEAR;
    wire clr = wr && (addr == `ISC_ADDR_IRQ_CLEAR || fclr);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_svc_onehot: assert property ($onehot0(svc))
        else $error("service not one-hot");
    a_clr_pend: assert property (clr && pend_set == 0
        |=> (pb & $past(wm)) == 0) else $error("pending not cleared");
    // only a clear write may drop a pending bit
    a_pend_hold: assert property (!clr |=> ($past(pb) & ~pb) == 0)
        else $error("pending lost");
    a_end_release: assert property (clr && (svc & wm) != 0
        |=> svc == 0 && service_end) else $error("service not ended");
    a_accept_set: assert property (irq_ack && $onehot(win_src) && !clr
        && (win_src & pb) != 0 && svc == 0 && !service_end
        |=> svc == $past(win_src)) else $error("accept lost");
    a_read_svc: assert property (rd && addr == `ISC_ADDR_IN_SERVICE
        |=> rdata == 32'($past(svc))) else $error("bad service read");
    a_read_wo: assert property (rd && (fclr
        || addr == `ISC_ADDR_IRQ_CLEAR) |=> rdata == 0)
        else $error("clear reg readable");
    a_reset_idle: assert property (!$past(rstn) |-> svc == 0)
        else $error("service after reset");
endmodule : isc_mon

bind isc_service isc_mon #(.NSRC(NSRC)) u_mon (.clock, .rstn, .addr,
    .wdata, .wr, .rd, .rdata, .pend_set, .win_src, .irq_ack,
    .source_pending_bits, .irq_in_service, .service_end);

// File: tb/isc_core_model.sv
module isc_core_model
    import isc_pkg::*;
(
    input logic clock,
    input logic rstn,
    input logic slow,
    input isc_src_t pend,
    input isc_src_t busy,
    output isc_src_t win_src,
    output logic [5:0] win_branch,
    output logic irq_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // accept the highest pending source
    // ********
    logic [1:0] lag;
    int hi;
    always_comb
    begin
        hi = 0;
        for (int i = 0; i < 26; i++)
            if (pend[i])
                hi = i;
    end
    always @(posedge clock or negedge rstn)
        if (!rstn)
        begin
            irq_ack <= 1'b0;
            win_src <= '0;
            win_branch <= '0;
            lag <= '0;
        end
        else if (irq_ack)
        begin
            irq_ack <= 1'b0;
            // stale winner is garbage once released
            win_src <= ~win_src;
            win_branch <= ~win_branch;
        end
        else if (pend != '0 && busy == '0)
        begin
            lag <= lag + 2'h1;
            if (!slow || lag == 2'h3)
            begin
                irq_ack <= 1'b1;
                win_src <= isc_src_t'(1) << hi;
                win_branch <= 6'(hi);
                lag <= '0;
            end
        end
endmodule : isc_core_model

// File: tb/irq_service_pending_clear_tb_top.sv
`include "isc_defs.svh"
module irq_service_pending_clear_tb_top
    import isc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_q = 1'b0;
    logic slow = 1'b0;
    logic [31:0] rdata;
    isc_src_t pend_set = '0;
    isc_src_t win_src, pend, svc;
    logic [5:0] win_branch;
    logic irq_ack, service_end, irq;
    logic [31:0] exp_q[$];
    int mismatches = 0;
    int num_checks = 0;
    int seed = 32'h1221C3E1;
    isc_service dut (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata,
        .pend_set, .win_src, .win_branch, .cur_prio(8'h1B), .irq_ack,
        .source_pending_bits(pend), .irq_in_service(svc), .service_end,
        .irq);
    isc_core_model core (.clock, .rstn, .slow, .pend, .busy(svc),
        .win_src, .win_branch, .irq_ack);
    initial
    begin
        forever #4 clock = ~clock;
    end
    // ********
    // bus and checking
    // ********
    task automatic chk(input string s, input logic [31:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic bus_wr(input logic [31:0] a, d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [31:0] a, e);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        rd <= 1'b0;
    endtask : bus_rd
    task automatic wait_svc(input isc_src_t e);
        int n;
        n = 0;
        while (svc !== e)
        begin
            @(posedge clock);
            #1;
            n++;
            if (n > 40)
            begin
                chk("wait", 32'(e), 32'(svc));
                end_of_test();
            end
        end
    endtask : wait_svc
    always @(posedge clock)
        rd_q <= rd;
    always @(negedge clock)
        if (rd_q)
            chk("rdata", exp_q.pop_front(), rdata);
    initial
    begin
        int k;
        int j;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        bus_rd(`ISC_ADDR_IN_SERVICE, 32'h0);
        for (int t = 0; t < 8; t++)
        begin
            k = 13 + $unsigned($random(seed)) % 13;
            j = $unsigned($random(seed)) % 13;
            slow <= t[0];
            bus_wr(`ISC_ADDR_INT_MASK, 32'(t[0]));
            pend_set <= (26'h1 << k) | (26'h1 << j);
            @(posedge clock);
            pend_set <= '0;
            wait_svc(26'h1 << k);
            bus_rd(`ISC_ADDR_MASTER_PRIO, {18'h0, 6'(k), 8'h1B});
            bus_rd(`ISC_ADDR_IN_SERVICE, 32'h1 << k);
            bus_wr(`ISC_ADDR_IRQ_CLEAR, 32'h1 << k);
            #1;
            chk("pend", 32'h1 << j, 32'(pend));
            chk("end", 32'h1, 32'(service_end));
            wait_svc(26'h1 << j);
            bus_wr(`ISC_ADDR_FIQ_CLEAR, 32'h1 << j);
            #1;
            chk("fpend", 32'h0, 32'(pend));
            bus_rd(`ISC_ADDR_INT_STATUS, 32'h3);
            bus_rd(`ISC_ADDR_INT_MASK, 32'(t[0]));
            chk("irq", 32'(t[0]), 32'(irq));
            bus_wr(`ISC_ADDR_INT_STATUS, 32'h7);
            @(posedge clock);
            #1;
            chk("irq0", 32'h0, 32'(irq));
        end
        // clear with nothing in service: flagged as stray
        bus_wr(`ISC_ADDR_IRQ_CLEAR, 32'h1);
        bus_rd(`ISC_ADDR_INT_STATUS, 32'h4);
        bus_rd(`ISC_ADDR_IN_SERVICE, 32'h0);
        bus_rd(32'h01E00100, 32'h0);
        bus_rd(`ISC_ADDR_IRQ_CLEAR, 32'h0);
        repeat (2) @(posedge clock);
        end_of_test();
    end
endmodule : irq_service_pending_clear_tb_top
